// ---- rtl/touch_core.sv ----
// Detection integrators and sleep/wake scheduler for a capacitive key matrix.
// Assumes the front end returns one burst result (above threshold or not) per request.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Reset returns every register and counter to the power-up state.
// - After reset a twenty millisecond init wait precedes all scanning.
// - A calibration completes within one full scan of the matrix.
// - Disabled keys are skipped in the burst sequence.
// - Burst chirp modulation is always on and has no control.
// - Above threshold, bursts repeat on the same key, inner count rising.
// - A burst below threshold clears that key's confirmation counts.
// - Each key has its own inner and outer limit, set per key.
// - Outer count rises when inner hits limit, else resets.
// - Outer count at limit marks the key touched and active.
// - Outer count rises at most once per full scan.
// - Idle device sleeps, wakes after the programmed interval, scans.
// - Host access during sleep wakes the device for a scan.
// - At least one full scan after any wake before sleeping.
// - Scans repeat while recent activity exists.
// - Any touch event in the last scan keeps the device awake.
module touch_core
   import touch_pkg::*;
(
   input  wire  logic                         clk,
   input  wire  logic                         rst_b,
   input  wire  logic                         hsel,
   input  wire  logic [31:0]                  haddr,
   input  wire  logic [1:0]                   htrans,
   input  wire  logic                         hwrite,
   input  wire  logic [2:0]                   hsize,
   input  wire  logic [31:0]                  hwdata,
   input  wire  logic                         hready,
   output logic       [31:0]                  hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic                               burst_req,
   output logic       [touch_pkg::KIDX_W-1:0] burst_key,
   output logic                               chirp_en,
   input  wire  logic                         burst_done,
   input  wire  logic                         burst_above,
   output logic                               irq
);
   import touch_pkg::*;

   phase_t                  phase_reg;
   logic [31:0]             tmr_reg;
   logic [15:0]             ms_reg;
   logic [KIDX_W-1:0]       key_reg;
   logic [NKEYS-1:0]        enable_reg;
   logic [15:0]             sleep_reg;
   logic [NKEYS-1:0]        active_reg;
   logic [IRQ_W-1:0]        istat_reg;
   logic [IRQ_W-1:0]        imask_reg;
   logic [KIDX_W-1:0]       ksel_reg;
   logic [LIM_W-1:0]        ilim_reg [NKEYS];
   logic [LIM_W-1:0]        olim_reg [NKEYS];
   logic [LIM_W-1:0]        icnt_reg [NKEYS];
   logic [LIM_W-1:0]        ocnt_reg [NKEYS];
   logic                    touch_seen_reg;
   logic                    wake_pend_reg;
   logic                    cal_req_reg;
   logic                    wr_pend_reg;
   logic                    rd_pend_reg;
   logic [7:0]              addr_reg;
   logic [31:0]             rdata_reg;
   logic                    cal_phase_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; the slave never stalls, so reads answer in the data phase
   wire         acc_ok    = hsel & hready & htrans[1];
   wire         wr_go     = acc_ok & hwrite;
   wire         rd_go     = acc_ok & ~hwrite;
   wire  [7:0]  wa        = addr_reg;
   wire         w_ctrl    = wr_pend_reg & (wa == OFF_CTRL);
   wire         w_enable  = wr_pend_reg & (wa == OFF_ENABLE);
   wire         w_sleep   = wr_pend_reg & (wa == OFF_SLEEP);
   wire         w_istat   = wr_pend_reg & (wa == OFF_IRQ_STAT);
   wire         w_imask   = wr_pend_reg & (wa == OFF_IRQ_MASK);
   wire         w_ksel    = wr_pend_reg & (wa == OFF_KSEL);
   wire         w_klim    = wr_pend_reg & (wa == OFF_KLIM);
   wire         host_acc  = acc_ok;

   // Read mux; unmapped offsets read zero
   wire  [7:0]  ra        = haddr[7:0];
   wire [31:0]  status_w  = {29'h0, phase_reg == S_SLEEP, phase_reg == S_CAL,
                             phase_reg == S_INIT};
   wire [31:0]  rd_mux    =
      (ra == OFF_ENABLE)   ? {8'h0, enable_reg} :
      (ra == OFF_SLEEP)    ? {16'h0, sleep_reg} :
      (ra == OFF_STATUS)   ? status_w :
      (ra == OFF_IRQ_STAT) ? {29'h0, istat_reg} :
      (ra == OFF_IRQ_MASK) ? {29'h0, imask_reg} :
      (ra == OFF_ACTIVE)   ? {8'h0, active_reg} :
      (ra == OFF_KSEL)     ? {27'h0, ksel_reg} :
      (ra == OFF_KLIM)     ? {24'h0, olim_reg[ksel_reg], ilim_reg[ksel_reg]} :
                             32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Scan sequencing: next enabled key after the current one
   logic [KIDX_W-1:0] next_key;
   logic              next_found;
   always_comb begin
      next_key   = key_reg;
      next_found = 1'b0;
      for (int i = NKEYS - 1; i >= 0; i--) begin
         if (i > int'(key_reg) && enable_reg[i]) begin
            next_key   = KIDX_W'(i);
            next_found = 1'b1;
         end
      end
   end

   logic [KIDX_W-1:0] first_key;
   logic              any_en;
   always_comb begin
      first_key = '0;
      any_en    = 1'b0;
      for (int i = NKEYS - 1; i >= 0; i--) begin
         if (enable_reg[i]) begin
            first_key = KIDX_W'(i);
            any_en    = 1'b1;
         end
      end
   end

   // Per-key terms of the current burst result
   wire [LIM_W-1:0] cur_icnt  = icnt_reg[key_reg];
   wire [LIM_W-1:0] cur_ocnt  = ocnt_reg[key_reg];
   wire             inner_hit = (cur_icnt + LIM_W'(1)) >= ilim_reg[key_reg];
   wire             outer_hit = (cur_ocnt + LIM_W'(1)) >= olim_reg[key_reg];
   wire             res_ok    = (phase_reg == S_BURST) & burst_done;
   wire             repeat_b  = res_ok & burst_above & ~inner_hit;
   wire             key_end   = res_ok & ~repeat_b;
   wire             scan_end  = key_end & ~next_found;
   // No touch can be declared while a calibration scan is clearing the counts
   wire             new_touch = key_end & burst_above & outer_hit &
                                ~active_reg[key_reg] & ~cal_phase_reg;
   wire             stay_up   = touch_seen_reg | new_touch | (|active_reg) |
                                wake_pend_reg | host_acc;
   wire             tmr_zero  = (tmr_reg == 32'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Phase machine: init wait, calibration scan, sleep, scan
   phase_t  phase_next;
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         S_INIT:  if (tmr_zero) phase_next = S_BURST;
         S_SLEEP: if (tmr_zero || host_acc || wake_pend_reg)
                     phase_next = S_BURST;
         S_BURST: if (scan_end && !stay_up && !cal_req_reg)
                     phase_next = S_SLEEP;
         S_CAL:   phase_next = S_BURST;
         S_SCAN:  phase_next = S_BURST;
         default: phase_next = S_INIT;
      endcase
   end

   // Phase, timers and key pointer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg     <= S_INIT;
         tmr_reg       <= INIT_CYC_W;
         ms_reg        <= 16'h0;
         key_reg       <= '0;
         cal_phase_reg <= 1'b1;
      end else begin
         phase_reg <= phase_next;
         if (phase_reg == S_INIT || phase_reg == S_SLEEP) begin
            if (phase_next == S_BURST) begin
               key_reg <= first_key;
            end else if (phase_reg == S_INIT) begin
               tmr_reg <= tmr_reg - 32'h1;
            end else if (ms_reg == 16'h0) begin
               tmr_reg <= tmr_reg - 32'h1;
               ms_reg  <= 16'(SLEEP_UNIT_W - 32'h1);
            end else begin
               ms_reg <= ms_reg - 16'h1;
            end
         end
         if (key_end) begin
            key_reg <= next_found ? next_key : first_key;
         end
         if (scan_end) begin
            // A calibration occupies exactly one scan, then normal scans follow
            cal_phase_reg <= (cal_req_reg && !cal_phase_reg) ||
                             (w_ctrl && hwdata[CTRL_CAL_BIT]);
         end
         if (phase_next == S_SLEEP && phase_reg != S_SLEEP) begin
            tmr_reg <= {16'h0, sleep_reg};
            ms_reg  <= 16'(SLEEP_UNIT_W - 32'h1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Activity trackers; a touch in the last scan keeps the part awake
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         touch_seen_reg <= 1'b0;
         wake_pend_reg  <= 1'b0;
         cal_req_reg    <= 1'b1;
      end else begin
         if (scan_end) begin
            touch_seen_reg <= new_touch;
         end else if (new_touch) begin
            touch_seen_reg <= 1'b1;
         end
         if (host_acc) begin
            wake_pend_reg <= 1'b1;
         end else if (scan_end) begin
            wake_pend_reg <= 1'b0;
         end
         if (w_ctrl && hwdata[CTRL_CAL_BIT]) begin
            cal_req_reg <= 1'b1;
         end else if (scan_end && cal_phase_reg) begin
            cal_req_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-key integrators
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int k = 0; k < NKEYS; k++) begin
            icnt_reg[k] <= '0;
            ocnt_reg[k] <= '0;
            ilim_reg[k] <= LIM_RST;
            olim_reg[k] <= LIM_RST;
         end
         active_reg <= '0;
      end else begin
         if (w_klim) begin
            ilim_reg[ksel_reg] <= hwdata[LIM_W-1:0];
            olim_reg[ksel_reg] <= hwdata[2*LIM_W-1:LIM_W];
         end
         if (res_ok) begin
            if (cal_phase_reg) begin
               icnt_reg[key_reg]   <= '0;
               ocnt_reg[key_reg]   <= '0;
               active_reg[key_reg] <= 1'b0;
            end else if (!burst_above) begin
               icnt_reg[key_reg]   <= '0;
               ocnt_reg[key_reg]   <= '0;
               active_reg[key_reg] <= 1'b0;
            end else if (!inner_hit) begin
               icnt_reg[key_reg] <= cur_icnt + LIM_W'(1);
            end else begin
               // One outer step per visit, and one visit per scan
               icnt_reg[key_reg] <= '0;
               if (outer_hit) begin
                  active_reg[key_reg] <= 1'b1;
               end else begin
                  ocnt_reg[key_reg] <= cur_ocnt + LIM_W'(1);
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers and sticky interrupt status (set beats clear)
   wire [IRQ_W-1:0] ev = {phase_reg == S_SLEEP && phase_next == S_BURST,
                          scan_end, new_touch};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_reg <= ENABLE_RST;
         sleep_reg  <= SLEEP_RST;
         istat_reg  <= '0;
         imask_reg  <= '0;
         ksel_reg   <= '0;
      end else begin
         if (w_enable) enable_reg <= hwdata[NKEYS-1:0];
         if (w_sleep)  sleep_reg  <= hwdata[15:0];
         if (w_imask)  imask_reg  <= hwdata[IRQ_W-1:0];
         if (w_ksel)   ksel_reg   <= (hwdata[KIDX_W-1:0] < KIDX_W'(NKEYS)) ?
                                     hwdata[KIDX_W-1:0] : ksel_reg;
         istat_reg <= (istat_reg & ~(w_istat ? hwdata[IRQ_W-1:0] : '0)) | ev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus pipeline and registered outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h0;
         hrdata      <= 32'h0;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         burst_req   <= 1'b0;
         burst_key   <= '0;
         chirp_en    <= 1'b1;
         irq         <= 1'b0;
      end else begin
         wr_pend_reg <= wr_go;
         rd_pend_reg <= rd_go;
         if (acc_ok) addr_reg <= haddr[7:0];
         if (rd_go)  hrdata <= rd_mux;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         burst_req <= (phase_next == S_BURST) && any_en && !res_ok;
         burst_key <= (phase_reg == S_BURST) ? (key_end ? (next_found ? next_key :
                      first_key) : key_reg) : first_key;
         chirp_en  <= 1'b1;
         irq       <= |(istat_reg & imask_reg);
      end
   end

   // The reset pulse width is the host's duty; nothing is checked here

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   touch_clears_a: assert property (@(posedge clk) disable iff (!rst_b)
      res_ok && !burst_above |=> icnt_reg[$past(key_reg)] == '0)
      else $error("inner count not cleared");
   inner_step_a: assert property (@(posedge clk) disable iff (!rst_b)
      repeat_b |=> phase_reg == S_BURST && key_reg == $past(key_reg))
      else $error("repeat burst moved key");
   mark_act_a: assert property (@(posedge clk) disable iff (!rst_b)
      new_touch |=> active_reg[$past(key_reg)])
      else $error("touched key not active");
   init_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_reg == S_INIT && !tmr_zero |=> phase_reg == S_INIT)
      else $error("left init early");
   wake_host_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_reg == S_SLEEP && host_acc |=> phase_reg == S_BURST)
      else $error("host did not wake");
   stay_awake_a: assert property (@(posedge clk) disable iff (!rst_b)
      scan_end && new_touch |=> phase_reg != S_SLEEP)
      else $error("slept after touch");
   sleep_scan_a: assert property (@(posedge clk) disable iff (!rst_b)
      phase_reg == S_BURST && phase_next == S_SLEEP |-> scan_end)
      else $error("slept without scan");
   chirp_on_a: assert property (@(posedge clk) disable iff (!rst_b)
      chirp_en)
      else $error("chirp disabled");
   skip_dis_a: assert property (@(posedge clk) disable iff (!rst_b)
      burst_req |-> enable_reg[burst_key] || $past(w_enable))
      else $error("disabled key burst");
   cv_touch: cover property (@(posedge clk) disable iff (!rst_b) new_touch);
   cv_sleep: cover property (@(posedge clk) disable iff (!rst_b) phase_reg == S_SLEEP);
   cv_wake:  cover property (@(posedge clk) disable iff (!rst_b)
      phase_reg == S_SLEEP ##1 phase_reg == S_BURST);
endmodule

`default_nettype wire

// ---- rtl/touch_pkg.sv ----
// Constants for the key-matrix detection and sleep scheduler core.
// Assumes a 40 MHz clock and an AHB-Lite register bus.
package touch_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned NKEYS         = 24;
   localparam int unsigned KIDX_W        = 5;
   localparam int unsigned LIM_W         = 4;
   // Reset pulse and init time, in their own units
   localparam int unsigned RST_PULSE_US  = 10;
   localparam int unsigned INIT_MS       = 20;
   localparam int unsigned RST_PULSE_CYC = (RST_PULSE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned INIT_CYC      = (INIT_MS * (CLK_HZ / 1000));
   localparam int unsigned SLEEP_UNIT_CYC = (CLK_HZ / 1000);   // Sleep counted in ms
   localparam logic [31:0] INIT_CYC_W    = 32'(INIT_CYC);
   localparam logic [31:0] SLEEP_UNIT_W  = 32'(SLEEP_UNIT_CYC);
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_ENABLE   = 8'h04;
   localparam logic [7:0] OFF_SLEEP    = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_ACTIVE   = 8'h18;
   localparam logic [7:0] OFF_KSEL     = 8'h1c;
   localparam logic [7:0] OFF_KLIM     = 8'h20;
   // Field positions
   localparam int unsigned CTRL_CAL_BIT = 0;
   localparam int unsigned ST_INIT_BIT  = 0;
   localparam int unsigned ST_CAL_BIT   = 1;
   localparam int unsigned ST_SLEEP_BIT = 2;
   localparam int unsigned IRQ_TOUCH    = 0;
   localparam int unsigned IRQ_SCAN     = 1;
   localparam int unsigned IRQ_WAKE     = 2;
   localparam int unsigned IRQ_W        = 3;
   // Reset values
   localparam logic [23:0] ENABLE_RST   = 24'hffffff;
   localparam logic [15:0] SLEEP_RST    = 16'h007d;
   localparam logic [LIM_W-1:0] LIM_RST = 4'h2;
   typedef enum logic [2:0] {S_INIT, S_CAL, S_SLEEP, S_SCAN, S_BURST} phase_t;
endpackage

// ---- sim/front_end_model.sv ----
// Behavioural acquisition front end: answers each burst request with one result.
// Assumes burst_req holds until burst_done, as the core's hand-over describes.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
   input  wire  logic        clk,
   input  wire  logic        rst_b,
   input  wire  logic        burst_req,
   input  wire  logic [4:0]  burst_key,
   input  wire  logic [23:0] touch,
   input  wire  logic [3:0]  dly,
   output logic              burst_done,
   output logic              burst_above
);
   logic [3:0] cnt_reg;
   // Result dly+1 cycles after the request is first seen; outside the valid cycle the flag toggles, never holds
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg     <= 4'h0;
         burst_done  <= 1'b0;
         burst_above <= 1'b0;
      end else begin
         burst_done  <= 1'b0;
         burst_above <= ~burst_above;
         // Restart after a result, so a held request is not answered twice at once
         if (burst_done || !burst_req) begin
            cnt_reg <= 4'h0;
         end else if (cnt_reg == dly) begin
            burst_done  <= 1'b1;
            burst_above <= touch[burst_key];
            cnt_reg     <= 4'h0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench for the touch detection core: AHB-Lite tasks and directed sequences.
// Assumes one slave on the bus, so hready is looped back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
   import touch_pkg::*;
   logic        clk, rst_b, hsel, hwrite, irq, hreadyout, hresp;
   logic        burst_req, chirp_en, burst_done, burst_above;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  burst_key;
   logic [23:0] touch, en_mask;
   logic [3:0]  dly;
   wire         hready = hreadyout;
   int          num_errors, compares, idle_run, max_idle, above2, bad_key, n;

   touch_core dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .burst_req(burst_req), .burst_key(burst_key),
      .chirp_en(chirp_en), .burst_done(burst_done), .burst_above(burst_above), .irq(irq));
   front_end_model fe (.clk(clk), .rst_b(rst_b), .burst_req(burst_req), .burst_key(burst_key),
      .touch(touch), .dly(dly), .burst_done(burst_done), .burst_above(burst_above));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; the watchdog allows for the long init wait
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (1_100_000) @(posedge clk);
      num_errors++;
      end_sim;
   end

   // Burst log: idle stretch, visits to disabled keys, above results on key 2
   always @(posedge clk) begin
      idle_run = burst_req ? 0 : idle_run + 1;
      if (idle_run > max_idle) max_idle = idle_run;
      if (burst_done && burst_req) begin
         if (en_mask[burst_key] !== 1'b1) bad_key++;
         if (burst_above && burst_key == 5'd2) above2++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks: address phase held until hready, then data phase
   task automatic bus_addr(input logic [7:0] a, input logic w);
      @(posedge clk);
      hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      bus_addr(a, 1'b1);
      hwdata <= v;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus_addr(a, 1'b0);
      do @(posedge clk); while (hready !== 1'b1);
      d = hrdata;
      `CHK(nm, e, d)
   endtask
   task automatic wait_req(input int lim);
      n = 0;
      while (burst_req !== 1'b1 && n < lim) begin @(posedge clk); n++; end
   endtask
   task automatic wait_idle;
      n = 0;
      while (idle_run < 200 && n < 200000) begin @(posedge clk); n++; end
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin @(posedge clk); n++; end
   endtask
   task automatic end_sim;
      if (num_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {num_errors, compares, idle_run, max_idle, above2, bad_key} = '0;
      rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; htrans = 2'b00;
      hsize = 3'b010; hwdata = 32'h0; touch = 24'h0; dly = 4'h2; en_mask = 24'hffffff;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      // Power-up state, an unmapped hole, fixed outputs
      chk_rd(OFF_ENABLE, 32'h00ffffff, "enable");
      chk_rd(OFF_SLEEP, 32'h0000007d, "sleep");
      chk_rd(OFF_KLIM, 32'h00000022, "klim");
      chk_rd(OFF_ACTIVE, 32'h0, "active");
      chk_rd(OFF_STATUS, 32'h1, "status_init");
      chk_rd(8'h40, 32'h0, "unmapped");
      `CHK("chirp", 1'b1, chirp_en)
      `CHK("hresp", 1'b0, hresp)
      // Four keys enabled, 1 ms sleep, per-key limits on key 2 only
      en_mask = 24'h0000a5;
      bus_wr(OFF_ENABLE, 32'h000000a5);
      bus_wr(OFF_SLEEP, 32'h1);
      bus_wr(OFF_IRQ_MASK, 32'h1 << IRQ_SCAN);
      bus_wr(OFF_KSEL, 32'h2);
      bus_wr(OFF_KLIM, 32'h23);
      chk_rd(OFF_KLIM, 32'h23, "klim2");
      bus_wr(OFF_KSEL, 32'h5);
      chk_rd(OFF_KLIM, 32'h22, "klim5");
      // Scanning must begin within 2000 cycles after the init wait ends
      wait_req(INIT_CYC + 2000);
      `CHK("init_end", 1'b1, burst_req)
      wait_irq(100000);
      `CHK("cal_scan", 1'b1, irq)
      bus_wr(OFF_IRQ_STAT, 32'h1 << IRQ_SCAN);
      repeat (3) @(posedge clk);
      `CHK("irq_clear", 1'b0, irq)
      // Slow front end; 3 inner times 2 outer crossings before key 2 goes active
      bus_wr(OFF_IRQ_MASK, 32'h1 << IRQ_TOUCH);
      dly <= 4'h6;
      above2 = 0;
      touch <= 24'h4;
      wait_irq(200000);
      `CHK("above_count", 32'd6, above2)
      chk_rd(OFF_ACTIVE, 32'h4, "active_k2");
      // Held touch keeps the core scanning past the sleep interval
      max_idle = 0;
      repeat (45000) @(posedge clk);
      `CHK("awake", 1'b1, max_idle < 200)
      `CHK("disabled_skip", 0, bad_key)
      touch <= 24'h0;
      repeat (2000) @(posedge clk);
      chk_rd(OFF_ACTIVE, 32'h0, "released");
      // Quiet: sleep, then wake by itself after about one interval
      bus_wr(OFF_IRQ_STAT, 32'h7);
      wait_idle;
      `CHK("asleep", 1'b0, burst_req)
      wait_req(SLEEP_UNIT_CYC + 1000);
      `CHK("auto_wake", 1'b1, burst_req && n > SLEEP_UNIT_CYC / 2)
      // Host access in sleep wakes it; a whole scan ends before sleeping
      wait_idle;
      chk_rd(OFF_IRQ_STAT, 32'h6, "wake_scan");
      wait_req(100);
      `CHK("host_wake", 1'b1, burst_req)
      // Reset in mid-run, held for the full pulse width
      rst_b <= 1'b0;
      repeat (400) @(posedge clk);
      `CHK("rst_req", 1'b0, burst_req)
      `CHK("rst_irq", 1'b0, irq)
      rst_b <= 1'b1;
      chk_rd(OFF_ACTIVE, 32'h0, "rst_active");
      chk_rd(OFF_SLEEP, 32'h0000007d, "rst_sleep");
      chk_rd(OFF_ENABLE, 32'h00ffffff, "rst_enable");
      chk_rd(OFF_STATUS, 32'h1, "rst_status");
      end_sim;
   end
endmodule
`default_nettype wire
